// ### core/vlhp_pkg.sv
// How it works
// - active lane strobes give transfer size
// - device drives wait to stretch access
// - ready held for three half-cycle samples
// - read data valid when ready shows
// - each strobe in a burst is one access
// - device offers 16-bit variable-latency mode
// - bus mode latched when reset releases
// - strap pattern 0100 selects this mode
// - polarity strap sets wait active level
// - wait held until internal arbitration done
// - memory/register select steers each access
package vlhp_pkg;

  // ==================================================================
  // timing
  localparam int unsigned VLHP_CLK_HZ = 10_000_000;
  localparam int unsigned VLHP_CLK_MHZ = VLHP_CLK_HZ / 1_000_000;
  // three half-cycle ready samples span this long at the host
  localparam int unsigned VLHP_READY_HOLD_NS = 150;
  localparam int unsigned VLHP_READY_HOLD_CYC =
    (VLHP_READY_HOLD_NS * VLHP_CLK_MHZ + 999) / 1000;
  localparam int unsigned VLHP_SYNC_STAGES = 2;

  // ==================================================================
  // widths
  localparam int unsigned VLHP_ADDR_W = 17;
  localparam int unsigned VLHP_DATA_W = 16;
  localparam int unsigned VLHP_LANES = 2;

  // ==================================================================
  // strap decode: {endian_bus_strap[3], [2], [1], [0]}
  localparam logic [3:0] VLHP_MODE_VARLAT_LE = 4'h4;

  // ==================================================================
  // access sequencer states
  typedef enum logic [1:0] {
    VLHP_IDLE  = 2'b00,
    VLHP_ARB   = 2'b01,
    VLHP_READY = 2'b10
  } vlhp_state_t;

endpackage

// ### core/vlhp_pins_if.sv
`timescale 1ns/10ps
// synchronised host pins, passed from the synchroniser to the core
interface vlhp_pins_if #(
  parameter int unsigned AW = 17,
  parameter int unsigned DW = 16
);
  logic cs_n;
  logic rd_n;
  logic wr_n;
  logic [1:0] lane_n;
  logic mr;
  logic [3:0] strap;
  logic wait_pol;
  logic [AW-1:0] addr;
  logic [DW-1:0] data;

  modport sync_out (output cs_n, rd_n, wr_n, lane_n, mr, strap, wait_pol, addr, data);
  modport core_in (input cs_n, rd_n, wr_n, lane_n, mr, strap, wait_pol, addr, data);
endinterface

// ### core/vlhp_pin_sync.sv
`timescale 1ns/10ps
module vlhp_pin_sync #(
  parameter int unsigned AW = 17,
  parameter int unsigned DW = 16
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // raw host pins
  input wire logic i_cs_n,
  input wire logic i_rd_n,
  input wire logic i_wr_n,
  input wire logic [1:0] i_lane_n,
  input wire logic i_mr,
  input wire logic [3:0] i_strap,
  input wire logic i_wait_pol,
  input wire logic [AW-1:0] i_addr,
  input wire logic [DW-1:0] i_data,
  // synchronised copy
  vlhp_pins_if.sync_out o_pins
);

  localparam int unsigned W = 11 + AW + DW;
  // strobes and lanes reset to their idle high level
  localparam logic [W-1:0] RST_VAL = {{5{1'b1}}, {(W-5){1'b0}}};

  logic [W-1:0] raw;
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  assign raw = {i_cs_n, i_rd_n, i_wr_n, i_lane_n, i_mr, i_strap, i_wait_pol, i_addr, i_data};

  // ==================================================================
  // two-stage synchroniser; only stage two is read downstream
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      meta_r <= RST_VAL;
      sync_r <= RST_VAL;
    end else begin
      meta_r <= raw;
      sync_r <= meta_r;
    end
  end

  assign {o_pins.cs_n, o_pins.rd_n, o_pins.wr_n, o_pins.lane_n, o_pins.mr,
          o_pins.strap, o_pins.wait_pol, o_pins.addr, o_pins.data} = sync_r;

endmodule

// ### core/vlhp_host_port.sv
`timescale 1ns/10ps
module vlhp_host_port #(
  parameter int unsigned ADDR_W = vlhp_pkg::VLHP_ADDR_W,
  parameter int unsigned DATA_W = vlhp_pkg::VLHP_DATA_W
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // host bus pins
  input wire logic i_host_chip_select_n,
  input wire logic i_read_strobe_n,
  input wire logic i_write_strobe_n,
  input wire logic [1:0] i_byte_lane_strobe_n,
  input wire logic i_mem_reg_sel,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_data,
  output logic [DATA_W-1:0] o_data,
  output logic o_data_oe,
  output logic o_wait,
  // configuration straps
  input wire logic [3:0] i_endian_bus_strap,
  input wire logic i_wait_polarity_strap,
  // internal resource arbiter side
  output logic o_acc_req,
  output logic o_acc_write,
  output logic o_acc_mem_sel,
  output logic [ADDR_W-1:0] o_acc_addr,
  output logic [DATA_W-1:0] o_acc_wdata,
  output logic [1:0] o_acc_byte_en,
  input wire logic i_acc_done,
  input wire logic [DATA_W-1:0] i_acc_rdata,
  // status
  output logic o_mode_ok
);

  localparam int unsigned HOLD = vlhp_pkg::VLHP_READY_HOLD_CYC;

  // ==================================================================
  // elaboration checks
  if (DATA_W != vlhp_pkg::VLHP_LANES * 8) begin : g_bad_width
    $error("data width must be two byte lanes");
  end
  if (ADDR_W < 1 || HOLD < 1 || HOLD > 3) begin : g_bad_param
    $error("unsupported address width or ready hold");
  end

  vlhp_pins_if #(.AW(ADDR_W), .DW(DATA_W)) pins ();

  vlhp_pin_sync #(.AW(ADDR_W), .DW(DATA_W)) u_sync (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_cs_n(i_host_chip_select_n),
    .i_rd_n(i_read_strobe_n),
    .i_wr_n(i_write_strobe_n),
    .i_lane_n(i_byte_lane_strobe_n),
    .i_mr(i_mem_reg_sel),
    .i_strap(i_endian_bus_strap),
    .i_wait_pol(i_wait_polarity_strap),
    .i_addr(i_addr),
    .i_data(i_data),
    .o_pins(pins)
  );

  // ==================================================================
  // strap capture after release, once the synchroniser has filled
  logic [1:0] strap_cnt_r;
  logic strap_taken_r;
  logic [3:0] mode_r;
  logic wait_pol_r;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      strap_cnt_r <= 2'h0;
      strap_taken_r <= 1'b0;
      mode_r <= 4'h0;
      wait_pol_r <= 1'b0;
    end else if (!strap_taken_r) begin
      strap_cnt_r <= strap_cnt_r + 2'h1;
      if (strap_cnt_r == 2'(vlhp_pkg::VLHP_SYNC_STAGES)) begin
        strap_taken_r <= 1'b1;
        mode_r <= pins.strap;
        wait_pol_r <= pins.wait_pol;
      end
    end
  end

  // only the variable-latency little-endian pattern enables the port
  assign o_mode_ok = strap_taken_r && (mode_r == vlhp_pkg::VLHP_MODE_VARLAT_LE);

  // ==================================================================
  // access sequencer
  vlhp_pkg::vlhp_state_t state_r;
  logic [1:0] hold_r;
  logic read_r;
  logic strobe_on;
  logic strobe_off;

  assign strobe_on = !pins.cs_n && (!pins.rd_n || !pins.wr_n);
  assign strobe_off = pins.rd_n && pins.wr_n;

  // one internal request per strobe assertion, even inside a burst
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_r <= vlhp_pkg::VLHP_IDLE;
      hold_r <= 2'h0;
    end else begin
      unique case (state_r)
        vlhp_pkg::VLHP_IDLE: begin
          if (o_mode_ok && strobe_on) begin
            state_r <= vlhp_pkg::VLHP_ARB;
          end
        end
        vlhp_pkg::VLHP_ARB: begin
          hold_r <= 2'h0;
          if (i_acc_done) begin
            state_r <= vlhp_pkg::VLHP_READY;
          end
        end
        vlhp_pkg::VLHP_READY: begin
          if (hold_r != 2'(HOLD)) begin
            hold_r <= hold_r + 2'h1;
          end
          // ready must outlive the host's three samples
          if ((strobe_off || pins.cs_n) && hold_r >= 2'(HOLD - 1)) begin
            state_r <= vlhp_pkg::VLHP_IDLE;
          end
        end
        default: begin
          state_r <= vlhp_pkg::VLHP_IDLE;
        end
      endcase
    end
  end

  // ==================================================================
  // request latch toward the internal arbiter
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_acc_req <= 1'b0;
      o_acc_write <= 1'b0;
      o_acc_mem_sel <= 1'b0;
      o_acc_addr <= '0;
      o_acc_wdata <= '0;
      o_acc_byte_en <= 2'h0;
      read_r <= 1'b0;
    end else if (state_r == vlhp_pkg::VLHP_IDLE && o_mode_ok && strobe_on) begin
      o_acc_req <= 1'b1;
      o_acc_write <= !pins.wr_n;
      read_r <= pins.wr_n;
      o_acc_mem_sel <= pins.mr;
      o_acc_addr <= pins.addr;
      o_acc_wdata <= pins.data;
      o_acc_byte_en <= ~pins.lane_n;
    end else if (state_r == vlhp_pkg::VLHP_ARB && i_acc_done) begin
      o_acc_req <= 1'b0;
    end
  end

  // ==================================================================
  // read data register, loaded when arbitration completes
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_data <= '0;
    end else if (state_r == vlhp_pkg::VLHP_ARB && i_acc_done && read_r) begin
      o_data <= i_acc_rdata;
    end
  end

  // drive the bus only while a read is in its ready phase
  assign o_data_oe = (state_r == vlhp_pkg::VLHP_READY) && read_r && !pins.rd_n;

  // ==================================================================
  // wait pin: busy from chip select until ready; xnor applies polarity
  logic waiting;
  assign waiting = o_mode_ok && !pins.cs_n && (state_r != vlhp_pkg::VLHP_READY);
  assign o_wait = waiting ~^ wait_pol_r;

  // ==================================================================
  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_grant;
    (state_r == vlhp_pkg::VLHP_ARB) && i_acc_done;
  endsequence
  sequence s_ready_two;
    (state_r == vlhp_pkg::VLHP_READY)[*2];
  endsequence

  property p_wait_arb;
    (state_r == vlhp_pkg::VLHP_ARB) && !pins.cs_n |-> o_wait == wait_pol_r;
  endproperty
  a_wait_arb: assert property (p_wait_arb) else $error("wait not active in arbitration");

  property p_ready_after_grant;
    s_grant |=> (state_r == vlhp_pkg::VLHP_READY) && (o_wait != wait_pol_r || pins.cs_n);
  endproperty
  a_ready_after_grant: assert property (p_ready_after_grant)
    else $error("ready not shown after grant");

  property p_ready_hold;
    s_grant |=> s_ready_two;
  endproperty
  a_ready_hold: assert property (p_ready_hold) else $error("ready held too briefly");

  property p_read_data;
    s_grant ##0 read_r |=> o_data == $past(i_acc_rdata);
  endproperty
  a_read_data: assert property (p_read_data) else $error("read data not loaded");

  // data loads on the edge that opens ready, so only later cycles must hold it
  property p_oe_read;
    o_data_oe |-> read_r && (state_r == vlhp_pkg::VLHP_READY)
      && (!$past(o_data_oe) || $stable(o_data));
  endproperty
  a_oe_read: assert property (p_oe_read) else $error("data driven outside read ready");

  property p_no_req_bad_mode;
    !o_mode_ok |-> !o_acc_req;
  endproperty
  a_no_req_bad_mode: assert property (p_no_req_bad_mode) else $error("request in wrong mode");

  property p_lanes;
    $rose(o_acc_req) |-> o_acc_byte_en == ~$past(pins.lane_n) && o_acc_mem_sel == $past(pins.mr);
  endproperty
  a_lanes: assert property (p_lanes) else $error("lane or select not captured");

  property p_one_per_strobe;
    $fell(o_acc_req) |-> !o_acc_req [*2];
  endproperty
  a_one_per_strobe: assert property (p_one_per_strobe) else $error("second request on one strobe");

  property p_straps_frozen;
    strap_taken_r && $past(strap_taken_r) |-> $stable(mode_r) && $stable(wait_pol_r);
  endproperty
  a_straps_frozen: assert property (p_straps_frozen) else $error("straps changed after capture");

endmodule

// ### dv/vlhp_arb_model.sv
`timescale 1ns/10ps
// ==========
// arbiter stand-in
module vlhp_arb_model (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // request side
  input wire logic i_req,
  input wire logic [16:0] i_addr,
  input wire logic [3:0] i_delay,
  // answer side
  output logic o_done,
  output logic [15:0] o_rdata
);
  logic [3:0] cnt_r;
  // answer i_delay+1 cycles after the request; data holds while counting and churns off the count and answer cycles so stale reads show
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cnt_r <= 4'h0;
      o_done <= 1'b0;
      o_rdata <= 16'h0000;
    end else if (i_req && !o_done) begin
      if (cnt_r == i_delay) begin
        o_done <= 1'b1;
        o_rdata <= i_addr[15:0] ^ 16'ha5c3;
      end else begin
        cnt_r <= cnt_r + 4'h1;
      end
    end else begin
      cnt_r <= 4'h0;
      o_done <= 1'b0;
      o_rdata <= ~o_rdata;
    end
  end
endmodule

// ### dv/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cs_n = 1'b1, rd_n = 1'b1, wr_n = 1'b1, mr = 1'b0, pol = 1'b1, req_q = 1'b0;
  logic [1:0] lane_n = 2'h3;
  logic [16:0] addr = 17'h00000;
  logic [15:0] wdata = 16'h0000;
  logic [3:0] strap = 4'h4;
  logic [3:0] delay = 4'h0;
  logic [15:0] seed = 16'h0016;
  logic [15:0] rd_data, acc_wdata, rdata;
  logic [16:0] acc_addr;
  logic [1:0] acc_be;
  logic oe, wait_o, req, acc_wr, acc_mem, done, mode_ok;
  logic [1:0] lanes [3] = '{2'h0, 2'h2, 2'h1};
  int err_count = 0;
  int n_checks = 0;
  int n_req = 0;

  // ==========
  // clock, design, arbiter
  initial begin
    forever #50 clk = ~clk;
  end
  vlhp_host_port dut_u (
    .i_clk(clk), .i_rst_n(rst_n), .i_host_chip_select_n(cs_n), .i_read_strobe_n(rd_n),
    .i_write_strobe_n(wr_n), .i_byte_lane_strobe_n(lane_n), .i_mem_reg_sel(mr),
    .i_addr(addr), .i_data(wdata), .o_data(rd_data), .o_data_oe(oe), .o_wait(wait_o),
    .i_endian_bus_strap(strap), .i_wait_polarity_strap(pol), .o_acc_req(req),
    .o_acc_write(acc_wr), .o_acc_mem_sel(acc_mem), .o_acc_addr(acc_addr),
    .o_acc_wdata(acc_wdata), .o_acc_byte_en(acc_be), .i_acc_done(done),
    .i_acc_rdata(rdata), .o_mode_ok(mode_ok));
  vlhp_arb_model arb_u (
    .i_clk(clk), .i_rst_n(rst_n), .i_req(req), .i_addr(acc_addr), .i_delay(delay),
    .o_done(done), .o_rdata(rdata));

  // count request rises: one per strobe, even inside one chip select
  always @(posedge clk) begin
    req_q <= req;
    if (req && !req_q) begin
      n_req <= n_req + 1;
    end
  end

  // ==========
  // helpers
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // lanes the host enables; only those bytes carry defined read data
  function automatic logic [15:0] lane_mask(input logic [1:0] ln);
    return {{8{!ln[1]}}, {8{!ln[0]}}};
  endfunction
  // stand-in arbiter answers with the address folded by a fixed pattern
  function automatic logic [15:0] exp_rdata(input logic [16:0] a, input logic [1:0] ln);
    return (a[15:0] ^ 16'ha5c3) & lane_mask(ln);
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic give_up();
    err_count++;
    $display("ERROR %0t: wait ran out", $time);
    tally_and_finish();
  endtask
  task automatic do_reset(input logic [3:0] s, input logic p);
    @(posedge clk);
    strap <= s;
    pol <= p;
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    @(negedge clk);
    check(mode_ok, s == vlhp_pkg::VLHP_MODE_VARLAT_LE);
    check(wait_o, !p);
  endtask

  // ==========
  // one strobe; ready must stand two cycles, read data valid while it does
  task automatic strobe(input logic wr, input logic ok);
    int k;
    int n0;
    n0 = n_req;
    rd_n <= wr;
    wr_n <= !wr;
    if (!ok) begin
      repeat (12) @(negedge clk);
      check(req, 1'b0);
      check(wait_o, !pol);
    end else begin
      for (k = 0; k < 20 && req !== 1'b1; k++) @(negedge clk);
      if (k == 20) give_up();
      check(wait_o, pol);
      check(oe, 1'b0);
      check(acc_wr, wr);
      check(acc_mem, mr);
      check(acc_addr, addr);
      check(acc_be, lane_n ^ 2'h3);
      if (wr) check(acc_wdata, wdata);
      // host keeps sampling ready until it shows
      for (k = 0; k < 40 && wait_o !== !pol; k++) @(negedge clk);
      if (k == 40) give_up();
      repeat (2) begin
        check(wait_o, !pol);
        check(oe, !wr);
        if (!wr) check(rd_data & lane_mask(lane_n), exp_rdata(addr, lane_n));
        @(negedge clk);
      end
    end
    @(posedge clk);
    rd_n <= 1'b1;
    wr_n <= 1'b1;
    repeat (4) @(posedge clk); // precharge well over one cycle
    @(negedge clk);
    check(oe, 1'b0);
    check(n_req, n0 + ok);
  endtask

  // n strobes under one chip select; odd strobes meet the slowest arbiter
  task automatic transfer(input logic wr, input logic [1:0] ln, input int n, input logic ok);
    int i;
    for (i = 0; i < n; i++) begin
      @(posedge clk);
      seed = lfsr(seed);
      addr <= {seed[5], seed}; // low lines of the host address
      mr <= seed[5];
      wdata <= lfsr(seed);
      delay <= i[0] ? 4'hf : seed[3:0];
      lane_n <= ln;
      @(posedge clk);
      if (i == 0) begin
        cs_n <= 1'b0; // a ready-capable select, address first
        repeat (2) @(posedge clk);
      end
      strobe(wr, ok);
    end
    @(posedge clk);
    cs_n <= 1'b1;
    lane_n <= 2'h3;
  endtask

  // ==========
  // main sequence
  initial begin
    do_reset(vlhp_pkg::VLHP_MODE_VARLAT_LE, 1'b1);
    for (int j = 0; j < 3; j++) begin
      transfer(1'b0, lanes[j], 2, 1'b1);
      transfer(1'b1, lanes[j], 2, 1'b1);
    end
    do_reset(vlhp_pkg::VLHP_MODE_VARLAT_LE, 1'b0);
    transfer(1'b1, 2'h0, 3, 1'b1);
    transfer(1'b0, 2'h0, 3, 1'b1);
    do_reset(4'hc, 1'b0);
    transfer(1'b0, 2'h0, 1, 1'b0);
    tally_and_finish();
  end
endmodule
